// ==== bench/fan_drive_properties.sv ====
// Concurrent checks on the fan drive and speed meter ports.
// Assumes it is bound to the top module and sees only its ports.
`default_nettype none

module fan_drive_properties import fan_drive_pkg::*; #(
    parameter int MEAS_TICKS = MEAS_TICKS_DEF,
    parameter int LF_STEP_CYCLES = LF_STEP_CYCLES_DEF
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [NUM_TACH-1:0] speedIn,
    input wire logic [NUM_DRIVE-1:0] driveOut
);
    logic acc;
    logic [3:0] modeShadow_q;
    logic [7:0] tcfgShadow_q;
    logic [7:0] duty0Shadow_q;
    logic [7:0] tcfgEff;

    assign acc = psel && penable && pready;
    assign tcfgEff = tcfgShadow_q | {{2{modeShadow_q[3]}}, {2{modeShadow_q[2]}}, {2{modeShadow_q[1]}},
        {2{modeShadow_q[0]}}};

    // Shadow copies of the registers that the checks depend on.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            modeShadow_q <= MODE_RST;
            tcfgShadow_q <= TCFG_RST;
            duty0Shadow_q <= DUTY_RST;
        end else if (acc && pwrite) begin
            if (paddr == ADDR_MODE) modeShadow_q <= pwdata[3:0];
            if (paddr == ADDR_TCFG) tcfgShadow_q <= pwdata[7:0];
            if (paddr == ADDR_DUTY0) duty0Shadow_q <= pwdata[7:0];
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    AST_PREADY_HIGH: assert property (psel |-> pready) else $error("pready low in a transfer");
    AST_MAPPED_OK: assert property (acc && paddr == ADDR_MODE |-> !pslverr) else $error("error on mapped");
    AST_UNMAPPED_ERR: assert property (acc && paddr == 8'hFC |-> pslverr) else $error("no error on unmapped");
    AST_UNMAPPED_ZERO: assert property (acc && paddr == 8'hFC |-> prdata == 32'h0) else $error("unmapped data");
    AST_WRITE_ZERO: assert property (acc && pwrite |-> prdata == 32'h0) else $error("data on write");
    AST_MODE_READ: assert property (acc && !pwrite && paddr == ADDR_MODE |-> prdata == {28'h0, modeShadow_q})
        else $error("mode readback wrong");
    AST_TCFG_READ: assert property (acc && !pwrite && paddr == ADDR_TCFG |-> prdata == {24'h0, tcfgEff})
        else $error("continuous bits wrong");
    AST_FULL_ON: assert property ((duty0Shadow_q == 8'hFF) [*5] |-> driveOut[0])
        else $error("full duty drive not on");
    AST_CONT_OFF: assert property ((duty0Shadow_q == 8'h00 && tcfgEff[1:0] == 2'b11) [*6] |-> !driveOut[0])
        else $error("continuous input stretched a drive");

    cover property (acc && pslverr);
    cover property ($rose(driveOut[0]));
    cover property (acc && !pwrite && paddr == ADDR_TCFG && prdata[5:4] == 2'b11);
endmodule

bind fan_drive_tach_period_meter fan_drive_properties #(.MEAS_TICKS(MEAS_TICKS), .LF_STEP_CYCLES(LF_STEP_CYCLES))
    chk (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .speedIn(speedIn),
    .driveOut(driveOut));

`default_nettype wire

// ==== bench/fan_drive_tach_period_meter_test.sv ====
// Self-checking bench for the fan drive and speed meter.
// Assumes the fan model on the speed inputs and an APB master made of tasks here.
`default_nettype none

module fan_drive_tach_period_meter_test;
    timeunit 1ns;
    timeprecision 1ps;
    import fan_drive_pkg::*;

    localparam int LIMIT = 99000;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [7:0] speedIn;
    logic [3:0] driveOut;
    logic [7:0] fourWire = 8'hFF;
    logic [3:0] perTicks = 4'h4;
    int error_cnt = 0;
    int compares = 0;
    int cycles = 0;

    always #4 clk_sys = ~clk_sys;

    fan_drive_tach_period_meter #(.MEAS_TICKS(16), .LF_STEP_CYCLES(4)) DUT (.clk_sys(clk_sys), .rst_n(rst_n),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .speedIn(speedIn), .driveOut(driveOut));
    fan_tach_model fans (.clk_sys(clk_sys), .driveOut(driveOut), .fourWire(fourWire), .perTicks(perTicks),
        .speedIn(speedIn));

    task automatic report_and_stop;
        $display("compares %0d mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic near(input logic [31:0] seen, input logic [31:0] exp, input int tol);
        check((seen + tol >= exp && seen <= exp + tol) ? exp : seen, exp);
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] d,
        output logic e);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk_sys);
        penable <= 1'b1;
        @(posedge clk_sys);
        while (pready !== 1'b1) @(posedge clk_sys);
        d = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        logic e;
        apb(1'b0, a, 32'h0, d, e);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] wd);
        logic [31:0] d;
        logic e;
        apb(1'b1, a, wd, d, e);
    endtask

    task automatic expect_rd(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] d;
        rd(a, d);
        check(d, exp);
    endtask

    task automatic read_val(input int j, output logic [31:0] v);
        logic [31:0] lo;
        logic [31:0] hi;
        rd(ADDR_VAL0 + 8'(8 * j), lo);
        rd(ADDR_VAL0 + 8'(8 * j) + VAL_HI_OFS, hi);
        v = {16'h0, hi[7:0], lo[7:0]};
    endtask

    task automatic test_reset;
        logic [31:0] v;
        check({28'h0, driveOut}, 32'hF);
        expect_rd(ADDR_MODE, 32'h0);
        for (int k = 0; k < 4; k++) expect_rd(ADDR_DUTY0 + 8'(4 * k), 32'hFF);
        expect_rd(ADDR_TCFG, 32'h0);
        for (int j = 0; j < 8; j++) begin
            read_val(j, v);
            check(v, 32'hFFFF);
        end
        rd(ADDR_VAL0, v);
        $display("test_reset done");
    endtask

    task automatic test_bus;
        logic [31:0] d;
        logic e;
        apb(1'b1, 8'hFC, 32'hA5, d, e);
        check({31'h0, e}, 32'h1);
        apb(1'b0, 8'hFC, 32'h0, d, e);
        check({31'h0, e}, 32'h1);
        check(d, 32'h0);
        rd(ADDR_STAT, d);
        check(d & 32'hFFFF00F0, 32'h0);
        $display("test_bus done");
    endtask

    task automatic test_continuous;
        logic [31:0] v;
        wr(ADDR_TCFG, 32'hFF);
        repeat (18 * TICK_CYCLES) @(posedge clk_sys);
        rd(ADDR_VAL0 + VAL_HI_OFS, v);
        check(v, 32'hFF);
        for (int j = 0; j < 8; j++) begin
            read_val(j, v);
            near(v, 32'(2 * (4 + j % 2)), 1);
        end
        $display("test_continuous done");
    endtask

    task automatic test_duty;
        int hi2;
        int hi3;
        int on0;
        wr(ADDR_TCFG, 32'h0F);
        wr(ADDR_MODE, 32'h4);
        expect_rd(ADDR_TCFG, 32'h3F);
        wr(ADDR_TCFG, 32'hFF);
        wr(ADDR_DUTY0, 32'h00);
        wr(ADDR_DUTY0 + 8'h08, 32'h80);
        wr(ADDR_DUTY0 + 8'h0C, 32'h40);
        hi2 = 0;
        hi3 = 0;
        on0 = 0;
        repeat (1020) @(posedge clk_sys);
        repeat (10200) begin
            @(posedge clk_sys);
            hi2 += int'(driveOut[2] === 1'b1);
            hi3 += int'(driveOut[3] === 1'b1);
            on0 += int'(driveOut[0] !== 1'b0);
        end
        check(32'(on0), 32'h0);
        near(32'(hi2), 32'd5120, 25);
        near(32'(hi3), 32'd2560, 25);
        $display("test_duty done");
    endtask

    task automatic test_stretch;
        logic [31:0] d;
        fourWire <= 8'hFC;
        perTicks <= 4'h3;
        wr(ADDR_MODE, 32'h0);
        wr(ADDR_TCFG, 32'hFC);
        d = 32'h0;
        while (d[8] !== 1'b1) rd(ADDR_STAT, d);
        check({31'h0, driveOut[0]}, 32'h1);
        check({31'h0, d[0]}, 32'h1);
        while (d[9:8] !== 2'b00) rd(ADDR_STAT, d);
        repeat (4) @(posedge clk_sys);
        check({31'h0, driveOut[0]}, 32'h0);
        read_val(0, d);
        near(d, 32'd6, 1);
        read_val(1, d);
        near(d, 32'd8, 1);
        $display("test_stretch done");
    endtask

    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == LIMIT) begin
            error_cnt++;
            report_and_stop();
        end
    end

    initial begin
        repeat (10) @(posedge clk_sys);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk_sys);
        test_reset();
        test_bus();
        test_continuous();
        test_duty();
        test_stretch();
        report_and_stop();
    end
endmodule

`default_nettype wire

// ==== bench/fan_tach_model.sv ====
// Behavioural model of eight fans, each with a tach output and an open-collector pull-up.
// Assumes drive outputs power the fans; four-wire fans are powered at all times.
`default_nettype none

module fan_tach_model import fan_drive_pkg::*; (
    input wire logic clk_sys,
    input wire logic [NUM_DRIVE-1:0] driveOut,
    input wire logic [NUM_TACH-1:0] fourWire,
    input wire logic [3:0] perTicks,
    output logic [NUM_TACH-1:0] speedIn
);
    int cnt [NUM_TACH];
    int per;
    logic pwr;

    // Each fan toggles its tach while powered; unpowered tach floats high on its pull-up.
    always @(posedge clk_sys) begin
        for (int j = 0; j < NUM_TACH; j++) begin
            per = (int'(perTicks) + j % 2) * TICK_CYCLES;
            pwr = fourWire[j] || driveOut[j / 2];
            if (!pwr) begin
                cnt[j] <= 0;
                speedIn[j] <= 1'b1;
            end else begin
                cnt[j] <= (cnt[j] + 1 >= per) ? 0 : cnt[j] + 1;
                speedIn[j] <= (cnt[j] >= per / 2);
            end
        end
    end
endmodule

`default_nettype wire

// ==== design/drive_pwm.sv ====
// One duty-cycle drive generator with a 255-step phase counter.
// Assumes a one-cycle step strobe from the owner that sets the drive rate.
`default_nettype none

module drive_pwm import fan_drive_pkg::*; (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic step,
    input wire logic [7:0] duty,
    output logic out
);

    logic [7:0] phaseQ;

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            phaseQ <= 8'h00;
        end else if (step) begin
            phaseQ <= (phaseQ == PWM_PHASE_MAX) ? 8'h00 : phaseQ + 8'h01;
        end
    end

    // Duty 0x00 is always off and 0xFF is always on.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            out <= 1'b0;
        end else begin
            out <= (phaseQ < duty); // (RL1)
        end
    end

endmodule

`default_nettype wire

// ==== design/fan_drive_tach_period_meter.sv ====
// Fan drive and speed meter: four duty-cycle drives, eight period meters, APB registers.
// Assumes an APB master on clk_sys and speed inputs arriving asynchronously from fans.
//
// Overview of operation
// (RL1) Each drive output's duty cycle is set from a software register.
// (RL2) Eight speed inputs exist but only four drive outputs.
// (RL3) Software picks low rate for 2/3-wire fans, high rate for 4-wire.
// (RL4) Software keeps a drive powering a 2-wire fan in low rate mode.
// (RL5) Chopped 3-wire fans get pulse stretching for valid speed readings.
// (RL6) While stretching, the drive stays fully on until the measurement completes.
// (RL7) Continuously measured inputs run without any stretching.
// (RL8) A 16-bit counter counts 90 kHz ticks across tach periods.
// (RL9) Each finished count is stored in that input's value register.
// (RL10) A set continuous bit makes its input measure continuously.
// (RL11) High rate drive mode sets the continuous bit of its paired inputs.
// (RL12) Stretching is synchronised between each drive and its speed inputs.
// (RL13) Drive n pairs with speed inputs 2n-1 and 2n.
// (RL14) High rate mode treats tach as always valid, no drive synchronisation.
// (RL15) Counting runs from first to third rising tach edge.
// (RL16) A reading of 0xFFFF means stalled or below about 100 rpm.
// (RL17) Reading the low byte freezes the high byte until it is read.
// (RL18) With stretching, measure once per second then restore programmed duty.
// (RL19) Every input has its own counter and value register.
// (RL20) The period counter saturates instead of wrapping.
//
// The APB register port and the register offsets were chosen for this implementation.
`default_nettype none

module fan_drive_tach_period_meter import fan_drive_pkg::*; #(
    parameter int MEAS_TICKS = MEAS_TICKS_DEF,
    parameter int LF_STEP_CYCLES = LF_STEP_CYCLES_DEF
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [NUM_TACH-1:0] speedIn,
    output logic [NUM_DRIVE-1:0] driveOut
);

    logic [NUM_TACH-1:0] speedMetaQ;
    logic [NUM_TACH-1:0] speedSyncQ;
    logic [TICK_W-1:0] tickCntQ;
    logic tickQ;
    logic [SLOW_W-1:0] measCntQ;
    logic measTickQ;
    logic [SLOW_W-1:0] lfCntQ;
    logic lfStepQ;
    logic [7:0] hfCntQ;
    logic hfStepQ;

    logic [NUM_DRIVE-1:0] modeQ;
    logic [7:0] dutyQ [NUM_DRIVE];
    logic [NUM_TACH-1:0] tcfgQ;
    logic [CNT_W-1:0] valueQ [NUM_TACH];
    logic [NUM_TACH-1:0] freezeQ;
    logic [7:0] hiHoldQ [NUM_TACH];
    logic [NUM_TACH-1:0] pendQ;
    logic [NUM_DRIVE-1:0] stretchOn;
    logic [NUM_DRIVE-1:0] pwmOut;
    logic [NUM_TACH-1:0] contEff;
    logic [NUM_TACH-1:0] startPulse;
    meas_t meas [NUM_TACH];

    logic setupRd;
    logic accWr;
    logic accRd;
    logic [31:0] rdNext;
    logic errNext;
    logic [NUM_TACH-1:0] loHit;
    logic [NUM_TACH-1:0] hiHit;

    // Speed inputs are asynchronous and pass two flops before use.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            speedMetaQ <= '1;
            speedSyncQ <= '1;
        end else begin
            speedMetaQ <= speedIn;
            speedSyncQ <= speedMetaQ;
        end
    end

    // The 90 kHz measurement tick.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            tickCntQ <= '0;
            tickQ <= 1'b0;
        end else if (tickCntQ == TICK_W'(TICK_CYCLES - 1)) begin
            tickCntQ <= '0;
            tickQ <= 1'b1; // (RL8)
        end else begin
            tickCntQ <= tickCntQ + 11'h001;
            tickQ <= 1'b0;
        end
    end

    // The once-per-second stretch measurement strobe, counted in ticks.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            measCntQ <= '0;
            measTickQ <= 1'b0;
        end else begin
            measTickQ <= 1'b0;
            if (tickQ) begin
                if (measCntQ == SLOW_W'(MEAS_TICKS - 1)) begin
                    measCntQ <= '0;
                    measTickQ <= 1'b1; // (RL18)
                end else begin
                    measCntQ <= measCntQ + 24'h000001;
                end
            end
        end
    end

    // Phase step strobes for the low and high rate drive modes.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            lfCntQ <= '0;
            lfStepQ <= 1'b0;
        end else if (lfCntQ == SLOW_W'(LF_STEP_CYCLES - 1)) begin
            lfCntQ <= '0;
            lfStepQ <= 1'b1;
        end else begin
            lfCntQ <= lfCntQ + 24'h000001;
            lfStepQ <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            hfCntQ <= '0;
            hfStepQ <= 1'b0;
        end else if (hfCntQ == 8'(HF_STEP_CYCLES - 1)) begin
            hfCntQ <= '0;
            hfStepQ <= 1'b1;
        end else begin
            hfCntQ <= hfCntQ + 8'h01;
            hfStepQ <= 1'b0;
        end
    end

    genvar k;
    genvar j;
    generate
        for (k = 0; k < NUM_DRIVE; k++) begin : g_drive
            drive_pwm u_pwm (
                .clk_sys(clk_sys),
                .rst_n(rst_n),
                .step(modeQ[k] ? hfStepQ : lfStepQ),
                .duty(dutyQ[k]),
                .out(pwmOut[k])
            );
            assign stretchOn[k] = pendQ[2*k] | pendQ[2*k+1]; // (RL13)
        end
        for (j = 0; j < NUM_TACH; j++) begin : g_tach // (RL2)
            assign contEff[j] = tcfgQ[j] | modeQ[j/2]; // (RL11)
            assign startPulse[j] = measTickQ & ~contEff[j] & ~pendQ[j]; // (RL5)
            tach_meter u_meter ( // (RL19)
                .clk_sys(clk_sys),
                .rst_n(rst_n),
                .tachLvl(speedSyncQ[j]),
                .tick(tickQ),
                .run(contEff[j]),
                .start(startPulse[j]),
                .result(meas[j])
            );
        end
    endgenerate

    // A pending stretched measurement holds its drive fully on until it is done.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            pendQ <= '0;
        end else begin
            for (int i = 0; i < NUM_TACH; i++) begin
                if (startPulse[i]) begin
                    pendQ[i] <= 1'b1; // (RL12)
                end else if (meas[i].done || contEff[i]) begin
                    pendQ[i] <= 1'b0; // (RL14)
                end
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            driveOut <= '0;
        end else begin
            driveOut <= pwmOut | stretchOn; // (RL6)
        end
    end

    // Finished counts land in the value registers, one per input.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            for (int i = 0; i < NUM_TACH; i++) begin
                valueQ[i] <= CNT_MAX;
            end
        end else begin
            for (int i = 0; i < NUM_TACH; i++) begin
                if (meas[i].done) begin
                    valueQ[i] <= meas[i].count; // (RL9)
                end
            end
        end
    end

    assign setupRd = psel & ~penable & ~pwrite;
    assign accWr = psel & penable & pwrite;
    assign accRd = psel & penable & ~pwrite;
    logic [31:0] prdataQ;
    logic slverrQ;

    assign pready = 1'b1;
    assign prdata = prdataQ;
    assign pslverr = slverrQ;

    always_comb begin
        rdNext = 32'h00000000;
        errNext = 1'b0;
        loHit = '0;
        hiHit = '0;
        for (int i = 0; i < NUM_TACH; i++) begin
            loHit[i] = (paddr == 8'(ADDR_VAL0 + VAL_STRIDE * i));
            hiHit[i] = (paddr == 8'(ADDR_VAL0 + VAL_STRIDE * i + VAL_HI_OFS));
        end
        if (paddr == ADDR_MODE) begin
            rdNext[NUM_DRIVE-1:0] = modeQ;
        end else if (paddr >= ADDR_DUTY0 && paddr < 8'(ADDR_DUTY0 + DUTY_STRIDE * NUM_DRIVE) &&
                     paddr[1:0] == 2'h0) begin
            rdNext[7:0] = dutyQ[2'(paddr[7:2] - 6'h01)];
        end else if (paddr == ADDR_TCFG) begin
            rdNext[NUM_TACH-1:0] = contEff; // (RL10)
        end else if (paddr == ADDR_STAT) begin
            rdNext[STAT_STRETCH_LSB +: NUM_DRIVE] = stretchOn;
            rdNext[STAT_PEND_LSB +: NUM_TACH] = pendQ;
        end else if (|loHit) begin
            for (int i = 0; i < NUM_TACH; i++) begin
                if (loHit[i]) begin
                    rdNext[7:0] = valueQ[i][7:0];
                end
            end
        end else if (|hiHit) begin
            for (int i = 0; i < NUM_TACH; i++) begin
                if (hiHit[i]) begin
                    rdNext[7:0] = freezeQ[i] ? hiHoldQ[i] : valueQ[i][15:8]; // (RL17)
                end
            end
        end else begin
            errNext = 1'b1;
        end
    end

    // Read data and error are captured in the setup cycle and shown in the access cycle.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            prdataQ <= 32'h00000000;
            slverrQ <= 1'b0;
        end else if (psel && !penable) begin
            prdataQ <= pwrite ? 32'h00000000 : rdNext;
            slverrQ <= errNext;
        end
    end

    // A low byte read snapshots the high byte; the high byte read releases it.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            freezeQ <= '0;
            for (int i = 0; i < NUM_TACH; i++) begin
                hiHoldQ[i] <= 8'h00;
            end
        end else begin
            for (int i = 0; i < NUM_TACH; i++) begin
                if (setupRd && loHit[i]) begin
                    freezeQ[i] <= 1'b1; // (RL17)
                    hiHoldQ[i] <= valueQ[i][15:8];
                end else if (accRd && hiHit[i]) begin
                    freezeQ[i] <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            modeQ <= MODE_RST;
            tcfgQ <= TCFG_RST;
            for (int i = 0; i < NUM_DRIVE; i++) begin
                dutyQ[i] <= DUTY_RST;
            end
        end else if (accWr) begin
            if (paddr == ADDR_MODE) begin
                modeQ <= pwdata[NUM_DRIVE-1:0];
            end else if (paddr == ADDR_TCFG) begin
                tcfgQ <= pwdata[NUM_TACH-1:0]; // (RL10)
            end else begin
                for (int i = 0; i < NUM_DRIVE; i++) begin
                    if (paddr == 8'(ADDR_DUTY0 + DUTY_STRIDE * i)) begin
                        dutyQ[i] <= pwdata[7:0]; // (RL1)
                    end
                end
            end
        end
    end

endmodule

`default_nettype wire

// ==== design/tach_meter.sv ====
// Period meter for one speed input, counting 90 kHz ticks over two tach periods.
// Assumes a synchronised input level and a one-cycle tick strobe from the owner.
`default_nettype none

module tach_meter import fan_drive_pkg::*; (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic tachLvl,
    input wire logic tick,
    input wire logic run,
    input wire logic start,
    output meas_t result
);

    meas_state_t stateQ;
    logic prevQ;
    logic secondQ;
    logic [CNT_W-1:0] cntQ;
    logic rise;

    assign rise = tachLvl & ~prevQ;

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            prevQ <= 1'b1;
        end else begin
            prevQ <= tachLvl;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            stateQ <= MS_IDLE;
            cntQ <= '0;
            secondQ <= 1'b0;
            result <= '0;
        end else begin
            result.done <= 1'b0;
            case (stateQ)
                MS_IDLE: begin
                    if (run | start) begin // (RL7)
                        stateQ <= MS_WAIT;
                        cntQ <= '0;
                    end
                end
                MS_WAIT: begin
                    if (rise) begin // (RL15)
                        stateQ <= MS_COUNT;
                        cntQ <= '0;
                        secondQ <= 1'b0;
                    end else if (tick) begin
                        if (cntQ == CNT_MAX) begin // (RL16)
                            result.done <= 1'b1;
                            result.count <= CNT_MAX;
                            stateQ <= MS_IDLE;
                        end else begin
                            cntQ <= cntQ + 16'h0001;
                        end
                    end
                end
                MS_COUNT: begin
                    if (rise && secondQ) begin // (RL15)
                        result.done <= 1'b1;
                        result.count <= cntQ;
                        stateQ <= MS_IDLE;
                    end else if (rise) begin
                        secondQ <= 1'b1;
                    end else if (tick) begin
                        if (cntQ == CNT_MAX) begin // (RL20)
                            result.done <= 1'b1;
                            result.count <= CNT_MAX;
                            stateQ <= MS_IDLE;
                        end else begin
                            cntQ <= cntQ + 16'h0001; // (RL8)
                        end
                    end
                end
                default: begin
                    stateQ <= MS_IDLE;
                end
            endcase
            // A stretch strobe drops any measurement left over from unpowered time and starts afresh.
            if (start) begin
                stateQ <= MS_WAIT; // (RL5)
                cntQ <= '0;
                result.done <= 1'b0;
            end
        end
    end

endmodule

`default_nettype wire

// ==== pkg/fan_drive_pkg.sv ====
// Constants, register map and shared types for the fan drive and speed meter.
// Assumes a single 125 MHz system clock and a 32-bit APB register bus.
`default_nettype none

package fan_drive_pkg;

    localparam int SYS_CLK_HZ = 125000000;
    localparam int TACH_CLK_HZ = 90000;
    localparam int TICK_CYCLES = (SYS_CLK_HZ + TACH_CLK_HZ / 2) / TACH_CLK_HZ;
    localparam int TICK_W = 11;
    localparam int MEAS_PERIOD_MS = 1000;
    localparam int MEAS_TICKS_DEF = MEAS_PERIOD_MS * (TACH_CLK_HZ / 1000);
    localparam int HF_STEP_CYCLES = 20;
    localparam int LF_STEP_CYCLES_DEF = 21786;
    localparam int SLOW_W = 24;

    localparam int NUM_DRIVE = 4;
    localparam int NUM_TACH = 8;
    localparam int CNT_W = 16;
    localparam logic [CNT_W-1:0] CNT_MAX = 16'hFFFF;
    localparam logic [7:0] PWM_PHASE_MAX = 8'hFE;

    localparam logic [7:0] ADDR_MODE = 8'h00;
    localparam logic [7:0] ADDR_DUTY0 = 8'h04;
    localparam logic [7:0] DUTY_STRIDE = 8'h04;
    localparam logic [7:0] ADDR_TCFG = 8'h14;
    localparam logic [7:0] ADDR_STAT = 8'h18;
    localparam logic [7:0] ADDR_VAL0 = 8'h40;
    localparam logic [7:0] VAL_STRIDE = 8'h08;
    localparam logic [7:0] VAL_HI_OFS = 8'h04;
    localparam int STAT_STRETCH_LSB = 0;
    localparam int STAT_PEND_LSB = 8;

    localparam logic [NUM_DRIVE-1:0] MODE_RST = 4'h0;
    localparam logic [7:0] DUTY_RST = 8'hFF;
    localparam logic [NUM_TACH-1:0] TCFG_RST = 8'h00;

    typedef enum logic [2:0] {
        MS_IDLE = 3'b001,
        MS_WAIT = 3'b010,
        MS_COUNT = 3'b100
    } meas_state_t;

    typedef struct packed {
        logic done;
        logic [CNT_W-1:0] count;
    } meas_t;

endpackage

`default_nettype wire
